// File: dv/epaio_pin_model.sv
// pad model standing outside the eight-bit port: resolves each pad level
// assumes driver enables are high while the port drives, one system clock
`timescale 1ns/1ps
module epaio_pin_model (
  input  wire logic       clk,      // system clock
  input  wire logic [7:0] pin_out,  // port output values
  input  wire logic [7:0] pin_oe,   // port driver enables
  input  wire logic [7:0] ext_en,   // outside driver enables
  input  wire logic [7:0] ext_val,  // outside driven values
  output logic      [7:0] pin_in    // resolved pad levels
);
  logic [7:0] last_q = 8'h00;       // levels of the previous cycle

  // port driver wins; the bench keeps ext_en high, so outside drivers overlap the port
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];     // port drives the pad
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];     // outside source drives
      end else begin
        pin_in[i] = ~last_q[i];     // floating: never a steady stale level
      end
    end
  end

  // history for the floating case
  always @(posedge clk) begin
    last_q <= pin_in;
  end
endmodule // epaio_pin_model

// File: dv/test_epaio_port.sv
// self-checking bench for the eight-bit port, pads closed by a pad model
// assumes one 25 MHz clock; strobes and configuration driven at rising edges
`timescale 1ns/1ps
module test_epaio_port
  import epaio_pkg::*;
;
  logic       clock    = 1'b0;  // system clock
  logic       srst     = 1'b1;  // reset, held at start
  logic [7:0] wr_data  = 8'h00; // write data
  logic [3:0] wr_sel   = 4'h0;  // {level, latch, dir, analog_select_register} strobes
  logic       osc_a    = 1'b1;  // pin six is a port pin
  logic       osc_b    = 1'b1;  // pin seven is a port pin
  logic       ref_en   = 1'b0;  // reference output on
  logic [1:0] cmp_en   = 2'h0;  // comparator routing {two, one}
  logic [1:0] cmp_val  = 2'h0;  // comparator values {two, one}
  logic [7:0] ext_en   = 8'hFF; // outside drivers enabled
  logic [7:0] ext_val  = 8'hFF; // outside levels
  logic [7:0] pin_in, pin_out, pin_oe, rd_level, rd_latch, rd_dir, analog_pin;
  logic [EPAIO_ANS_BITS-1:0] rd_analog_select_register; // analog-select read
  logic       tmr_clk;                 // timer clock from pin four
  int         n_fail   = 0;     // mismatches
  int         n_checks = 0;     // comparisons
  int         cycles   = 0;     // timeout counter

  always #20 clock = ~clock;

  epaio_port i_dut (
    .CLOCK(clock), .SRST(srst), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .WR_DATA(wr_data), .WR_LEVEL(wr_sel[3]), .WR_LATCH(wr_sel[2]), .WR_DIR(wr_sel[1]),
    .WR_ANALOG_SELECT_REGISTER(wr_sel[0]), .RD_LEVEL(rd_level), .RD_LATCH(rd_latch), .RD_DIR(rd_dir),
    .RD_ANALOG_SELECT_REGISTER(rd_analog_select_register), .OSC_A_PORT(osc_a), .OSC_B_PORT(osc_b), .REF_OUT_EN(ref_en),
    .CMP1_OUT_EN(cmp_en[0]), .CMP1_OUT(cmp_val[0]), .CMP2_OUT_EN(cmp_en[1]),
    .CMP2_OUT(cmp_val[1]), .TMR_CLK_IN(tmr_clk), .ANALOG_PIN(analog_pin));

  epaio_pin_model i_pads (
    .clk(clock), .pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pin_in));

  // verdict and end of run, the one exit point
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // hang guard: whole run needs under a hundred cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_fail++;
      final_report();
    end
  end

  // wait n edges, then step off the edge so updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // one write, strobes high for exactly one edge; several strobes share data
  task automatic wr(input logic [3:0] sel, input logic [7:0] v);
    @(posedge clock);
    wr_data <= v;
    wr_sel  <= sel;
    @(posedge clock);
    wr_sel  <= 4'h0;
    #1;
  endtask

  // outside level change at an edge
  task automatic ext(input logic [7:0] v);
    @(posedge clock);
    ext_val <= v;
    #1;
  endtask

  // the one comparison for all eight-bit results
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  initial begin
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    tick(4);
    // reset state: analog pins read zero, pin four digital
    chk("dir", EPAIO_DIR_RST, rd_dir);
    chk("latch", EPAIO_LAT_RST, rd_latch);
    chk("analog_select_register", {3'h0, EPAIO_ANS_RST}, {3'h0, rd_analog_select_register});
    chk("analog", 8'h2F, analog_pin);
    chk("oe", 8'h00, pin_oe);
    chk("level", 8'hD0, rd_level);
    $display("test reset done");
    // digital inputs and the two-flop synchroniser delay
    wr(4'h1, 8'h00);
    tick(4);
    chk("level", 8'hFF, rd_level);
    chk("analog", 8'h00, analog_pin);
    chk("analog_select_register", 8'h00, {3'h0, rd_analog_select_register});
    ext(8'h5A);
    tick(2);
    chk("level", 8'hFF, rd_level);
    tick(1);
    chk("level", 8'h5A, rd_level);
    chk("tmr", 8'h01, {7'h00, tmr_clk});
    $display("test input done");
    // level write loads latch; latch read differs from pads
    wr(4'h8, 8'hFF);
    wr(4'h2, 8'hF0);
    ext(8'h00);
    tick(4);
    chk("oe", 8'h0F, pin_oe);
    chk("out", 8'h0F, pin_out);
    chk("latch", 8'hFF, rd_latch);
    chk("level", 8'h0F, rd_level);
    chk("tmr", 8'h00, {7'h00, tmr_clk});
    wr(4'hC, 8'hF5);
    tick(4);
    chk("latch", 8'hF5, rd_latch);
    chk("level", 8'h05, rd_level);
    $display("test output done");
    // analog select gates input only
    ext(8'hFF);
    wr(4'h1, 8'h1F);
    tick(4);
    chk("oe", 8'h0F, pin_oe);
    chk("out", 8'h05, pin_out);
    chk("level", 8'hD0, rd_level);
    wr(4'h1, 8'h00);
    // reference output takes pin two away from the port
    @(posedge clock);
    ref_en <= 1'b1;
    tick(4);
    chk("oe", 8'h0B, pin_oe);
    chk("out", 8'h01, pin_out);
    chk("level", 8'hF1, rd_level);
    $display("test shared done");
    // comparator outputs replace latch values on pins four and five
    wr(4'h2, 8'hC0);
    @(posedge clock);
    ref_en <= 1'b0;
    cmp_en <= 2'h3;
    for (int v = 0; v < 4; v++) begin
      @(posedge clock);
      cmp_val <= v[1:0];
      tick(2);
      chk("out", {2'h0, v[1:0], 4'h5}, pin_out);
    end
    $display("test comparator done");
    @(posedge clock);
    cmp_en <= 2'h0;
    // oscillator owns pins six and seven
    osc_a <= 1'b0;
    osc_b <= 1'b0;
    wr(4'h2, 8'h00);
    tick(4);
    chk("oe", 8'h3F, pin_oe);
    chk("latch", 8'h35, rd_latch);
    chk("level", 8'h35, rd_level);
    wr(4'h2, 8'hC0);
    tick(1);
    chk("dir", 8'h00, rd_dir);
    @(posedge clock);
    osc_a <= 1'b1;
    osc_b <= 1'b1;
    tick(2);
    chk("dir", 8'hC0, rd_dir);
    wr(4'h2, 8'hFF);
    $display("test oscillator done");
    // mid-run reset brings every register back to its reset value
    @(posedge clock);
    srst <= 1'b1;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    tick(4);
    chk("dir", EPAIO_DIR_RST, rd_dir);
    chk("latch", EPAIO_LAT_RST, rd_latch);
    chk("analog", 8'h2F, analog_pin);
    chk("level", 8'hD0, rd_level);
    $display("test reset again done");
    final_report();
  end
endmodule // test_epaio_port

// File: rtl/epaio_pin_slice.sv
// combinational next-state for one pin: driver, data and digital input gate
// assumes every input is on the system clock; results are registered above
`timescale 1ns/1ps
module epaio_pin_slice (
  input  wire logic dir,      // direction bit, one = input
  input  wire logic lat,      // output latch bit
  input  wire logic alt_en,   // peripheral output routed here
  input  wire logic alt_dat,  // peripheral output value
  input  wire logic out_kill, // peripheral owns the pin, no driver
  input  wire logic in_kill,  // digital input path off
  input  wire logic pin_sync, // synchronised pin level
  output logic      oe_d,     // next driver enable
  output logic      out_d,    // next driven value
  output logic      lvl_d     // next level-read bit
);

  // driver follows direction unless a peripheral withholds the pin
  assign oe_d  = ~dir & ~out_kill;
  // routed peripheral output takes priority over latch data
  assign out_d = oe_d & (alt_en ? alt_dat : lat);
  // a disabled input buffer reads as zero
  assign lvl_d = pin_sync & ~in_kill;

endmodule // epaio_pin_slice

// File: rtl/epaio_pkg.sv
// package for the eight-bit general-purpose port with shared pin functions
// assumes one system clock and a synchronous active-high reset
package epaio_pkg;

  localparam int          EPAIO_PINS     = 8;     // port width
  localparam int          EPAIO_ANS_BITS = 5;     // analog-select bits
  localparam int          EPAIO_SYNC_STG = 2;     // synchroniser depth

  // reset values
  localparam logic [7:0]  EPAIO_DIR_RST  = 8'hFF; // all pins inputs
  localparam logic [7:0]  EPAIO_LAT_RST  = 8'h00; // latches cleared
  localparam logic [4:0]  EPAIO_ANS_RST  = 5'h1F; // all analog-capable pins analog

  // pin positions of shared functions
  localparam int          EPAIO_PIN_REF  = 2;     // reference output pin
  localparam int          EPAIO_PIN_TMR  = 4;     // timer clock / comparator one
  localparam int          EPAIO_PIN_CMP2 = 5;     // comparator two / analog bit four
  localparam int          EPAIO_PIN_OSCA = 6;     // oscillator feedback pin
  localparam int          EPAIO_PIN_OSCB = 7;     // oscillator input pin

  // analog-select bit positions
  localparam int          EPAIO_ANS_LOW  = 0;     // bits 0..3 map to pins 0..3
  localparam int          EPAIO_ANS_HIGH = 4;     // bit 4 maps to pin five

endpackage : epaio_pkg

// File: rtl/epaio_port.sv
// eight-bit bidirectional port with direction, latch and level registers
// assumes same-clock register strobes from the core, raw pins from outside,
// and peripheral enables coming from the comparator and oscillator logic
`timescale 1ns/1ps
module epaio_port
  import epaio_pkg::*;
(
  input  wire logic                      CLOCK,         // system clock, 25 MHz
  input  wire logic                      SRST,          // synchronous reset, high
  // pins
  input  wire logic [EPAIO_PINS-1:0]     PIN_IN,        // pad levels, asynchronous
  output logic      [EPAIO_PINS-1:0]     PIN_OUT,       // pad output values
  output logic      [EPAIO_PINS-1:0]     PIN_OE,        // pad driver enables, high drives
  // register writes
  input  wire logic [EPAIO_PINS-1:0]     WR_DATA,       // write data, all registers
  input  wire logic                      WR_LEVEL,      // write pin-level register
  input  wire logic                      WR_LATCH,      // write output latch register
  input  wire logic                      WR_DIR,        // write direction register
  input  wire logic                      WR_ANALOG_SELECT_REGISTER,      // write analog-select register
  // register reads
  output logic      [EPAIO_PINS-1:0]     RD_LEVEL,      // pin-level register
  output logic      [EPAIO_PINS-1:0]     RD_LATCH,      // output latch register
  output logic      [EPAIO_PINS-1:0]     RD_DIR,        // direction register
  output logic      [EPAIO_ANS_BITS-1:0] RD_ANALOG_SELECT_REGISTER,      // analog-select bits
  // configuration and peripherals
  input  wire logic                      OSC_A_PORT,    // pin six used as port pin
  input  wire logic                      OSC_B_PORT,    // pin seven used as port pin
  input  wire logic                      REF_OUT_EN,    // comparator reference output on
  input  wire logic                      CMP1_OUT_EN,   // comparator one output routed
  input  wire logic                      CMP1_OUT,      // comparator one output value
  input  wire logic                      CMP2_OUT_EN,   // comparator two output routed
  input  wire logic                      CMP2_OUT,      // comparator two output value
  output logic                           TMR_CLK_IN,    // timer clock from pin four
  output logic      [EPAIO_PINS-1:0]     ANALOG_PIN     // pins handed to analog inputs
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [EPAIO_PINS-1:0]     dir_q;       // direction bits
  logic [EPAIO_PINS-1:0]     lat_q;       // output latch bits
  logic [EPAIO_ANS_BITS-1:0] ans_q;       // analog-select bits
  logic [EPAIO_PINS-1:0]     lat_d;       // next latch
  logic [EPAIO_PINS-1:0]     pin_sync;    // synchronised pads
  logic [EPAIO_PINS-1:0]     oe_d;        // next driver enables
  logic [EPAIO_PINS-1:0]     out_d;       // next pad values
  logic [EPAIO_PINS-1:0]     lvl_d;       // next level reads

  // ------------------------------------------------------------------
  // pin ownership decode
  // ------------------------------------------------------------------
  wire [EPAIO_PINS-1:0] port_pin;         // pins usable as port pins
  wire [EPAIO_PINS-1:0] ana_pin;          // pins with analog selection
  wire [EPAIO_PINS-1:0] ref_pin;          // pin taken by reference output
  wire [EPAIO_PINS-1:0] alt_en;           // comparator outputs routed
  wire [EPAIO_PINS-1:0] alt_dat;          // comparator output values
  wire [EPAIO_PINS-1:0] out_kill;         // drivers withheld
  wire [EPAIO_PINS-1:0] in_kill;          // input buffers off

  // oscillator pins leave the port per oscillator configuration
  assign port_pin = {OSC_B_PORT, OSC_A_PORT, 6'h3F};

  // low four analog bits sit on pins 0..3, the fifth on pin five
  assign ana_pin  = {2'h0, ans_q[EPAIO_ANS_HIGH], 1'b0,
                     ans_q[EPAIO_ANS_HIGH-1:EPAIO_ANS_LOW]};

  // reference output claims pin two both ways
  assign ref_pin  = {5'h00, REF_OUT_EN, 2'h0};

  // pin four shares comparator one, pin five comparator two
  assign alt_en   = {2'h0, CMP2_OUT_EN, CMP1_OUT_EN, 4'h0};
  assign alt_dat  = {2'h0, CMP2_OUT, CMP1_OUT, 4'h0};

  // analog selection is absent here: output path untouched
  assign out_kill = ~port_pin | ref_pin;
  // analog, reference or oscillator use blocks the digital input
  assign in_kill  = ~port_pin | ref_pin | ana_pin;

  // ------------------------------------------------------------------
  // input synchroniser
  // ------------------------------------------------------------------
  epaio_sync #(
    .WIDTH (EPAIO_PINS)
  ) u_sync (
    .clk  (CLOCK),
    .srst (SRST),
    .d    (PIN_IN),
    .q    (pin_sync)
  );

  // ------------------------------------------------------------------
  // per-pin slices
  // ------------------------------------------------------------------
  // eight independent pins, no shared state between them
  for (genvar g = 0; g < EPAIO_PINS; g++) begin : g_pin
    epaio_pin_slice u_slice (
      .dir      (dir_q[g]),
      .lat      (lat_q[g]),
      .alt_en   (alt_en[g]),
      .alt_dat  (alt_dat[g]),
      .out_kill (out_kill[g]),
      .in_kill  (in_kill[g]),
      .pin_sync (pin_sync[g]),
      .oe_d     (oe_d[g]),
      .out_d    (out_d[g]),
      .lvl_d    (lvl_d[g])
    );
  end

  // ------------------------------------------------------------------
  // latch write select
  // ------------------------------------------------------------------
  // both level and latch writes land in the latch; latch write wins a tie
  assign lat_d = WR_LATCH ? WR_DATA :
                 WR_LEVEL ? WR_DATA : lat_q;

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------
  // reset leaves all pins inputs and analog pins analog
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      dir_q <= EPAIO_DIR_RST;
      lat_q <= EPAIO_LAT_RST;
      ans_q <= EPAIO_ANS_RST;
    end else begin
      lat_q <= lat_d;
      if (WR_DIR) begin
        dir_q <= WR_DATA;
      end
      if (WR_ANALOG_SELECT_REGISTER) begin
        ans_q <= WR_DATA[EPAIO_ANS_BITS-1:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // pad outputs, registered so the pads never glitch on decode
  // ------------------------------------------------------------------
  // one cycle of latency is traded for clean pad edges
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      PIN_OE  <= '0;
      PIN_OUT <= '0;
    end else begin
      PIN_OE  <= oe_d;
      PIN_OUT <= out_d;
    end
  end

  // ------------------------------------------------------------------
  // read-back registers
  // ------------------------------------------------------------------
  // oscillator-owned pins read zero in every register
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      RD_LEVEL   <= '0;
      RD_LATCH   <= '0;
      RD_DIR     <= '0;
      RD_ANALOG_SELECT_REGISTER   <= '0;
      TMR_CLK_IN <= 1'b0;
      ANALOG_PIN <= '0;
    end else begin
      RD_LEVEL   <= lvl_d;
      RD_LATCH   <= lat_q & port_pin;
      RD_DIR     <= dir_q & port_pin;
      RD_ANALOG_SELECT_REGISTER   <= ans_q;
      TMR_CLK_IN <= pin_sync[EPAIO_PIN_TMR];
      ANALOG_PIN <= ana_pin;
    end
  end

  // analog pins still obey direction; software must keep them inputs
  // so the latch does not fight the analog source

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  // direction one: no driver next cycle, on any pin
  property p_dir_in;
    @(posedge CLOCK) disable iff (SRST)
    1'b1 |=> ((PIN_OE & $past(dir_q)) == 8'h00);
  endproperty
  a_dir_in: assert property (p_dir_in)
    else $error("driver enabled on a pin set as input");

  // direction zero on a plain pin: driver on, latch value out
  property p_dir_out;
    @(posedge CLOCK) disable iff (SRST)
    !dir_q[0] |=> PIN_OE[0] && (PIN_OUT[0] == $past(lat_q[0]));
  endproperty
  a_dir_out: assert property (p_dir_out)
    else $error("output pin does not drive its latch value");

  // level write reaches the latch
  property p_level_wr;
    @(posedge CLOCK) disable iff (SRST)
    WR_LEVEL && !WR_LATCH |=> lat_q == $past(WR_DATA);
  endproperty
  a_level_wr: assert property (p_level_wr)
    else $error("level register write missed the latch");

  // latch write reads back two cycles later on plain pins
  property p_latch_rd;
    @(posedge CLOCK) disable iff (SRST)
    WR_LATCH |-> ##2 RD_LATCH[5:0] == $past(WR_DATA[5:0], 2);
  endproperty
  a_latch_rd: assert property (p_latch_rd)
    else $error("latch read-back differs from written value");

  // oscillator-owned pin six reads zero and is never driven
  property p_osc_zero;
    @(posedge CLOCK) disable iff (SRST)
    !OSC_A_PORT |=> !RD_LEVEL[6] && !RD_DIR[6] && !RD_LATCH[6] && !PIN_OE[6];
  endproperty
  a_osc_zero: assert property (p_osc_zero)
    else $error("oscillator pin visible as port pin");

  // first cycle after reset: analog selected, all inputs
  property p_reset_val;
    @(posedge CLOCK) disable iff (SRST)
    $fell(SRST) |-> (ans_q == EPAIO_ANS_RST) && (dir_q == EPAIO_DIR_RST) ##1 (RD_LEVEL[3:0] == 4'h0);
  endproperty
  a_reset_val: assert property (p_reset_val)
    else $error("reset state of analog or direction bits wrong");

  // analog pin reads zero
  property p_ana_zero;
    @(posedge CLOCK) disable iff (SRST)
    ans_q[0] && ans_q[4] |=> !RD_LEVEL[0] && !RD_LEVEL[5];
  endproperty
  a_ana_zero: assert property (p_ana_zero)
    else $error("analog pin shows digital level");

  // analog selection keeps the output path
  property p_ana_drive;
    @(posedge CLOCK) disable iff (SRST)
    ans_q[1] && !dir_q[1] |=> PIN_OE[1] && (PIN_OUT[1] == $past(lat_q[1]));
  endproperty
  a_ana_drive: assert property (p_ana_drive)
    else $error("analog selection disturbed output driver");

  // reference output takes pin two both ways
  property p_ref_pin;
    @(posedge CLOCK) disable iff (SRST)
    REF_OUT_EN |=> !PIN_OE[2] && !RD_LEVEL[2];
  endproperty
  a_ref_pin: assert property (p_ref_pin)
    else $error("pin two still digital with reference output on");

  // routed comparator one replaces latch data on pin four
  property p_cmp_drive;
    @(posedge CLOCK) disable iff (SRST)
    CMP1_OUT_EN && !dir_q[4] |=> PIN_OE[4] && (PIN_OUT[4] == $past(CMP1_OUT));
  endproperty
  a_cmp_drive: assert property (p_cmp_drive)
    else $error("comparator output not on pin four");

  // pin four level appears three edges after the pad
  property p_sync_lat;
    @(posedge CLOCK) disable iff (SRST)
    (!SRST)[*4] |-> (RD_LEVEL[4] == $past(PIN_IN[4], 3)) && (TMR_CLK_IN == RD_LEVEL[4]);
  endproperty
  a_sync_lat: assert property (p_sync_lat)
    else $error("pin level latency is not three cycles");

  // direction write lands whole on the next edge
  property p_dir_wr;
    @(posedge CLOCK) disable iff (SRST)
    WR_DIR |=> dir_q == $past(WR_DATA);
  endproperty
  a_dir_wr: assert property (p_dir_wr)
    else $error("direction write did not land");

  // analog-select write reads back two edges later
  property p_analog_select_register_rd;
    @(posedge CLOCK) disable iff (SRST)
    WR_ANALOG_SELECT_REGISTER |-> ##2 RD_ANALOG_SELECT_REGISTER == $past(WR_DATA[EPAIO_ANS_BITS-1:0], 2);
  endproperty
  a_analog_select_register_rd: assert property (p_analog_select_register_rd)
    else $error("analog-select read-back differs from written value");

  // oscillator-owned pin seven reads zero and is never driven
  property p_osc_b_zero;
    @(posedge CLOCK) disable iff (SRST)
    !OSC_B_PORT |=> !RD_LEVEL[EPAIO_PIN_OSCB] && !RD_DIR[EPAIO_PIN_OSCB] &&
                    !RD_LATCH[EPAIO_PIN_OSCB] && !PIN_OE[EPAIO_PIN_OSCB];
  endproperty
  a_osc_b_zero: assert property (p_osc_b_zero)
    else $error("oscillator pin seven visible as port pin");

  // routed comparator two replaces latch data on pin five
  property p_cmp2_drive;
    @(posedge CLOCK) disable iff (SRST)
    CMP2_OUT_EN && !dir_q[EPAIO_PIN_CMP2] |=>
      PIN_OE[EPAIO_PIN_CMP2] && (PIN_OUT[EPAIO_PIN_CMP2] == $past(CMP2_OUT));
  endproperty
  a_cmp2_drive: assert property (p_cmp2_drive)
    else $error("comparator two output not on pin five");

  // an undriven pad never shows a high output value
  property p_out_gate;
    @(posedge CLOCK) disable iff (SRST)
    1'b1 |-> (PIN_OUT & ~PIN_OE) == 8'h00;
  endproperty
  a_out_gate: assert property (p_out_gate)
    else $error("pad value high while its driver is off");

endmodule // epaio_port

// File: rtl/epaio_sync.sv
// two-stage level synchroniser for the pin inputs
// assumes the inputs are asynchronous to CLOCK
`timescale 1ns/1ps
module epaio_sync
  import epaio_pkg::*;
#(
  parameter int WIDTH = EPAIO_PINS            // bits synchronised
) (
  input  wire logic             clk,          // system clock
  input  wire logic             srst,         // synchronous reset
  input  wire logic [WIDTH-1:0] d,            // asynchronous levels
  output logic      [WIDTH-1:0] q             // synchronised levels
);

  logic [WIDTH-1:0] meta_q;                   // first stage, read only by stage two

  // first stage feeds only the second: no logic may tap it
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // epaio_sync
